// ===== hdl/lpd_pkg.sv
// constants, register map and types of the card-detect window compare
// How it works
// - upper I border is built from bits 7:6 of three border registers
// - I measurement above the upper I border raises a detect request
// - lower Q border is a read/write field in bits 5:0
// - upper Q border in bits 5:0; Q above it raises a request
// - lower I border in bits 5:0; I below it raises a request
// - a raised request sets the detect flag in the first status register
// - last I result is captured read-only in bits 5:0, bits 7:6 zero
// - last Q result is captured read-only in bits 5:0, bit 7 zero
// - suppress bit 6 blocks further requests until the next detect_start
package lpd_pkg;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int LPD_VAL_W  = 6;
  localparam int LPD_REG_W  = 8;
  localparam int LPD_ADDR_W = 12;
  localparam int LPD_DATA_W = 32;
  localparam int LPD_ST_W   = 2;

  // ---------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------------
  localparam logic [9:0] LPD_IDX_QLOW  = 10'h03F;
  localparam logic [9:0] LPD_IDX_QHIGH = 10'h040;
  localparam logic [9:0] LPD_IDX_ILOW  = 10'h041;
  localparam logic [9:0] LPD_IDX_RES_I = 10'h042;
  localparam logic [9:0] LPD_IDX_RES_Q = 10'h043;
  localparam logic [9:0] LPD_IDX_STAT  = 10'h050;
  localparam logic [9:0] LPD_IDX_MASK  = 10'h051;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int LPD_VAL_HI  = 5;
  localparam int LPD_BRD_HI  = 7;
  localparam int LPD_BRD_LO  = 6;
  localparam int LPD_SUPP    = 6;
  localparam int LPD_ST_DET  = 0;
  localparam int LPD_ST_MEAS = 1;

  // ---------------------------------------------------------------------
  // reset values and bus answers
  // ---------------------------------------------------------------------
  localparam logic [7:0] LPD_RST_BORDER = 8'h00;
  localparam logic [5:0] LPD_RST_RESULT = 6'h00;
  localparam logic [1:0] LPD_RST_ST     = 2'h0;
  localparam logic [1:0] LPD_RESP_OKAY  = 2'h0;
  localparam logic [1:0] LPD_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LPD_SEL_QLOW,
    LPD_SEL_QHIGH,
    LPD_SEL_ILOW,
    LPD_SEL_RES_I,
    LPD_SEL_RES_Q,
    LPD_SEL_STAT,
    LPD_SEL_MASK,
    LPD_SEL_NONE
  } lpd_sel_t;

  // word-aligned decode; any other address selects nothing
  function automatic lpd_sel_t lpd_sel_of(
    input logic [LPD_ADDR_W-1:0] a
  );
    lpd_sel_t s;
    s = LPD_SEL_NONE;
    if (a == {LPD_IDX_QLOW, 2'b00}) s = LPD_SEL_QLOW;
    else if (a == {LPD_IDX_QHIGH, 2'b00}) s = LPD_SEL_QHIGH;
    else if (a == {LPD_IDX_ILOW, 2'b00}) s = LPD_SEL_ILOW;
    else if (a == {LPD_IDX_RES_I, 2'b00}) s = LPD_SEL_RES_I;
    else if (a == {LPD_IDX_RES_Q, 2'b00}) s = LPD_SEL_RES_Q;
    else if (a == {LPD_IDX_STAT, 2'b00}) s = LPD_SEL_STAT;
    else if (a == {LPD_IDX_MASK, 2'b00}) s = LPD_SEL_MASK;
    return s;
  endfunction

endpackage

// ===== hdl/lpd_top.sv
// card-detect window compare with result capture and AXI4-Lite registers
`timescale 1ns/1ps
module lpd_top #(
  parameter int ADDR_W = lpd_pkg::LPD_ADDR_W
) (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // write address
  input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // write data
  input  wire logic [lpd_pkg::LPD_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // read address
  input  wire logic [ADDR_W-1:0]              s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // read data
  output logic [lpd_pkg::LPD_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // measurement from the analog front end
  input  wire logic                           detect_start,
  input  wire logic [lpd_pkg::LPD_VAL_W-1:0]  in_phase_meas,
  input  wire logic [lpd_pkg::LPD_VAL_W-1:0]  quadrature_meas,
  input  wire logic                           meas_valid,
  // interrupt
  output logic                                irq
);
  import lpd_pkg::*;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [LPD_REG_W-1:0]  q_low_reg_q;
  logic [LPD_REG_W-1:0]  q_high_reg_q;
  logic [LPD_REG_W-1:0]  i_low_reg_q;
  logic [LPD_VAL_W-1:0]  in_phase_result_q;
  logic [LPD_VAL_W-1:0]  quadrature_result_q;
  logic                  detect_irq_suppress_q;
  logic [LPD_ST_W-1:0]   irq_status_first_q;
  logic [LPD_ST_W-1:0]   irq_mask_q;
  logic                  irq_q;
  logic                  aw_full_q;
  logic                  w_full_q;
  logic [ADDR_W-1:0]     awaddr_q;
  logic [LPD_REG_W-1:0]  wdata_q;
  logic                  wstrb0_q;
  logic                  awready_q;
  logic                  wready_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [LPD_DATA_W-1:0] rdata_q;
  logic [1:0]            rresp_q;

  logic [LPD_VAL_W-1:0]  in_phase_upper_border;
  logic                  i_below;
  logic                  i_above;
  logic                  i_outside;
  logic                  q_below;
  logic                  q_above;
  logic                  q_outside;
  logic                  det_set;
  logic [LPD_ST_W-1:0]   st_set;
  logic [LPD_ST_W-1:0]   st_clr;
  logic                  wr_fire;
  logic                  wr_en;
  lpd_sel_t              wr_sel;
  lpd_sel_t              rd_sel;
  logic [LPD_REG_W-1:0]  rd_byte;

  // ---------------------------------------------------------------------
  // border assembly and window compare
  // ---------------------------------------------------------------------
  // upper I border
  assign in_phase_upper_border = {q_low_reg_q[LPD_BRD_HI:LPD_BRD_LO],
                                  q_high_reg_q[LPD_BRD_HI:LPD_BRD_LO],
                                  i_low_reg_q[LPD_BRD_HI:LPD_BRD_LO]};

  lpd_win_cmp #(
    .W       (LPD_VAL_W)
  ) u_cmp_i (
    .value   (in_phase_meas),
    .lower   (i_low_reg_q[LPD_VAL_HI:0]),
    .upper   (in_phase_upper_border),
    .below   (i_below),
    .above   (i_above),
    .outside (i_outside)
  );

  lpd_win_cmp #(
    .W       (LPD_VAL_W)
  ) u_cmp_q (
    .value   (quadrature_meas),
    .lower   (q_low_reg_q[LPD_VAL_HI:0]),
    .upper   (q_high_reg_q[LPD_VAL_HI:0]),
    .below   (q_below),
    .above   (q_above),
    .outside (q_outside)
  );

  assign det_set = meas_valid && (i_outside || q_outside)
                   && !detect_irq_suppress_q;

  // ---------------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------------
  // address and data are held until both are in; response follows both
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel  = lpd_sel_of(awaddr_q);
  assign wr_en   = wr_fire && wstrb0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_full_q <= 1'b1;
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_full_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata[LPD_REG_W-1:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (bvalid_q && s_axi_bready) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= LPD_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == LPD_SEL_NONE) ? LPD_RESP_SLVERR
                                           : LPD_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // border registers
  // ---------------------------------------------------------------------
  // read/write borders
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_low_reg_q  <= LPD_RST_BORDER;
      q_high_reg_q <= LPD_RST_BORDER;
      i_low_reg_q  <= LPD_RST_BORDER;
    end else if (wr_en) begin
      if (wr_sel == LPD_SEL_QLOW) begin
        q_low_reg_q <= wdata_q;
      end else if (wr_sel == LPD_SEL_QHIGH) begin
        q_high_reg_q <= wdata_q;
      end else if (wr_sel == LPD_SEL_ILOW) begin
        i_low_reg_q <= wdata_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= LPD_RST_ST;
    end else if (wr_en && wr_sel == LPD_SEL_MASK) begin
      irq_mask_q <= wdata_q[LPD_ST_W-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // results and suppress
  // ---------------------------------------------------------------------
  // capture of the last valid measurement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_phase_result_q   <= LPD_RST_RESULT;
      quadrature_result_q <= LPD_RST_RESULT;
    end else if (meas_valid) begin
      in_phase_result_q   <= in_phase_meas;
      quadrature_result_q <= quadrature_meas;
    end
  end

  // suppress until next procedure
  // a software write in the start cycle wins over the release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_irq_suppress_q <= 1'b0;
    end else if (wr_en && wr_sel == LPD_SEL_RES_Q) begin
      detect_irq_suppress_q <= wdata_q[LPD_SUPP];
    end else if (detect_start) begin
      detect_irq_suppress_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------------
  always_comb begin
    st_set              = '0;
    st_set[LPD_ST_DET]  = det_set;
    st_set[LPD_ST_MEAS] = meas_valid;
    st_clr              = '0;
    if (wr_en && wr_sel == LPD_SEL_STAT) begin
      st_clr = wdata_q[LPD_ST_W-1:0];
    end
    // setting suppress also clears the pending detect flag
    if (wr_en && wr_sel == LPD_SEL_RES_Q && wdata_q[LPD_SUPP]) begin
      st_clr[LPD_ST_DET] = 1'b1;
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_first_q <= LPD_RST_ST;
    end else begin
      irq_status_first_q <= (irq_status_first_q & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_first_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------------
  assign rd_sel = lpd_sel_of(s_axi_araddr);

  always_comb begin
    rd_byte = '0;
    case (rd_sel)
      LPD_SEL_QLOW:  rd_byte = q_low_reg_q;
      LPD_SEL_QHIGH: rd_byte = q_high_reg_q;
      LPD_SEL_ILOW:  rd_byte = i_low_reg_q;
      LPD_SEL_RES_I: rd_byte = {2'b00, in_phase_result_q};
      LPD_SEL_RES_Q: rd_byte = {1'b0, detect_irq_suppress_q,
                                quadrature_result_q};
      LPD_SEL_STAT:  rd_byte = {6'h00, irq_status_first_q};
      LPD_SEL_MASK:  rd_byte = {6'h00, irq_mask_q};
      default:       rd_byte = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= LPD_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h000000, rd_byte};
      rresp_q   <= (rd_sel == LPD_SEL_NONE) ? LPD_RESP_SLVERR
                                            : LPD_RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_upper_lsb_write: assert property (
    wr_en && wr_sel == LPD_SEL_ILOW
    |=> in_phase_upper_border[1:0] == $past(wdata_q[7:6]))
    else $error("upper I border low bits not taken from lower I reg");

  a_i_above_flag: assert property (
    meas_valid && in_phase_meas > in_phase_upper_border
    && !detect_irq_suppress_q |=> irq_status_first_q[LPD_ST_DET])
    else $error("I above upper border did not set detect flag");

  a_qlow_write: assert property (
    wr_en && wr_sel == LPD_SEL_QLOW
    |=> s_axi_bvalid
    && q_low_reg_q[LPD_VAL_HI:0] == $past(wdata_q[LPD_VAL_HI:0]))
    else $error("lower Q border not written with its response");

  a_q_above_flag: assert property (
    meas_valid && quadrature_meas > q_high_reg_q[5:0]
    && !detect_irq_suppress_q |=> irq_status_first_q[LPD_ST_DET])
    else $error("Q above upper border did not set detect flag");

  a_i_below_flag: assert property (
    meas_valid && in_phase_meas < i_low_reg_q[5:0]
    && !detect_irq_suppress_q |=> irq_status_first_q[LPD_ST_DET])
    else $error("I below lower border did not set detect flag");

  a_flag_to_irq: assert property (
    irq_status_first_q[LPD_ST_DET] && irq_mask_q[LPD_ST_DET]
    |=> irq)
    else $error("unmasked detect flag did not raise irq");

  a_inside_no_flag: assert property (
    !irq_status_first_q[LPD_ST_DET] && !(meas_valid && (i_outside
    || q_outside)) |=> !irq_status_first_q[LPD_ST_DET])
    else $error("detect flag set without an out-of-window value");

  a_result_i_read: assert property (
    s_axi_arvalid && arready_q && rd_sel == LPD_SEL_RES_I
    |=> s_axi_rdata[LPD_BRD_HI:LPD_BRD_LO] == 2'b00
    && s_axi_rdata[LPD_VAL_HI:0] == $past(in_phase_result_q))
    else $error("I result read back wrong");

  a_result_q_read: assert property (
    s_axi_arvalid && arready_q && rd_sel == LPD_SEL_RES_Q
    |=> s_axi_rdata[7] == 1'b0
    && s_axi_rdata[5:0] == $past(quadrature_result_q))
    else $error("Q result read back wrong");

  a_suppress_hold: assert property (
    detect_irq_suppress_q && !irq_status_first_q[LPD_ST_DET]
    |=> !irq_status_first_q[LPD_ST_DET])
    else $error("detect flag set while suppressed");

  a_q_below_flag: assert property (
    meas_valid && quadrature_meas < q_low_reg_q[5:0]
    && !detect_irq_suppress_q |=> irq_status_first_q[LPD_ST_DET])
    else $error("Q below lower border did not set detect flag");

  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");

  c_detect_irq: cover property (
    meas_valid && i_outside ##1 irq_status_first_q[LPD_ST_DET] ##1 irq);
  c_suppressed: cover property (
    meas_valid && q_outside && detect_irq_suppress_q);
  c_write_done: cover property (
    wr_en && wr_sel == LPD_SEL_QHIGH ##1 s_axi_bvalid && s_axi_bready);
  c_status_clear: cover property (
    wr_en && wr_sel == LPD_SEL_STAT && irq_status_first_q != '0);

endmodule

// ===== hdl/lpd_win_cmp.sv
// window comparator for one measurement channel
`timescale 1ns/1ps
module lpd_win_cmp #(
  parameter int W = lpd_pkg::LPD_VAL_W
) (
  // measurement and borders
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] lower,
  input  wire logic [W-1:0] upper,
  // results
  output logic              below,
  output logic              above,
  output logic              outside
);
  import lpd_pkg::*;

  // strict compares: a value equal to a border stays inside
  always_comb begin
    below   = value < lower;
    above   = value > upper;
    outside = below || above;
  end

endmodule

// ===== tb/lpd_top_tb_top.sv
// self-checking bench for the card-detect window compare
`timescale 1ns/1ps
module lpd_top_tb_top;
  import lpd_pkg::*;
  // ---------------------------------------------------------------
  // signals and addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] A_QL  = {LPD_IDX_QLOW, 2'b00};
  localparam logic [11:0] A_QH  = {LPD_IDX_QHIGH, 2'b00};
  localparam logic [11:0] A_IL  = {LPD_IDX_ILOW, 2'b00};
  localparam logic [11:0] A_RI  = {LPD_IDX_RES_I, 2'b00};
  localparam logic [11:0] A_RQ  = {LPD_IDX_RES_Q, 2'b00};
  localparam logic [11:0] A_ST  = {LPD_IDX_STAT, 2'b00};
  localparam logic [11:0] A_MK  = {LPD_IDX_MASK, 2'b00};
  localparam logic [11:0] A_BAD = 12'h200;
  localparam logic [1:0]  OK    = LPD_RESP_OKAY;
  localparam logic [1:0]  ERR   = LPD_RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic        s_axi_bvalid, s_axi_rvalid, irq;
  logic        detect_start = 1'b0, meas_valid = 1'b0;
  logic [5:0]  in_phase_meas = 6'h00, quadrature_meas = 6'h00;
  int          failures = 0;
  int          cmp_count = 0;
  logic [7:0]  ql, qh, il;
  logic [5:0]  iv, qv;
  logic        det;

  always #4 aclk = ~aclk;

  lpd_top lpd_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .detect_start, .in_phase_meas,
    .quadrature_meas, .meas_valid, .irq
  );

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string m);
    $display("CHECK FAILED t=%0t %s", $time, m);
    failures++;
  endtask

  task automatic cmp_word(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) fail($sformatf("%s data %h exp %h", m, g, e));
  endtask

  task automatic cmp_resp(input logic [1:0] g, e, input string m);
    cmp_count++;
    if (g !== e) fail($sformatf("%s resp %h exp %h", m, g, e));
  endtask

  task automatic cmp_irq(input logic g, e);
    cmp_count++;
    if (g !== e) fail($sformatf("irq %b exp %b", g, e));
  endtask

  // bready is held high throughout, so the answer is taken on sight
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!s_axi_bvalid && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n >= 50) begin
      fail("write timeout");
      final_report();
    end else begin
      cmp_resp(s_axi_bresp, e, "write");
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (!s_axi_rvalid && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n >= 50) begin
      fail("read timeout");
      final_report();
    end else begin
      cmp_word(s_axi_rdata, e, $sformatf("read %h", a));
      cmp_resp(s_axi_rresp, er, "read");
    end
  endtask

  // one-cycle measurement; waits until the irq level has settled
  task automatic measure(input logic [5:0] i, q);
    @(posedge aclk);
    in_phase_meas   <= i;
    quadrature_meas <= q;
    meas_valid      <= 1'b1;
    @(posedge aclk);
    meas_valid      <= 1'b0;
    in_phase_meas   <= ~i;
    quadrature_meas <= ~q;
    repeat (2) @(posedge aclk);
  endtask

  task automatic set_borders(input logic [7:0] a, b, c);
    wr(A_QL, {24'h0, a}, OK);
    wr(A_QH, {24'h0, b}, OK);
    wr(A_IL, {24'h0, c}, OK);
  endtask

  function automatic logic exp_det(input logic [7:0] a, b, c,
                                   input logic [5:0] i, q);
    logic [5:0] iu;
    iu = {a[7:6], b[7:6], c[7:6]};
    return (i > iu) || (i < c[5:0]) || (q > b[5:0]) || (q < a[5:0]);
  endfunction

  // picks values on, just past, or away from a border
  function automatic logic [5:0] near(input logic [5:0] lo, hi);
    case ($urandom % 5)
      0: return lo;
      1: return lo - 6'h01;
      2: return hi;
      3: return hi + 6'h01;
      default: return 6'($urandom);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(42));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_QL, 32'h0, OK);
    rd(A_RI, 32'h0, OK);
    rd(A_RQ, 32'h0, OK);
    rd(A_ST, 32'h0, OK);
    rd(A_BAD, 32'h0, ERR);
    wr(A_BAD, 32'hFF, ERR);
    for (int k = 0; k < 4; k++) begin
      ql = 8'($urandom);
      qh = 8'($urandom);
      il = 8'($urandom);
      set_borders(ql, qh, il);
      rd(A_QL, {24'h0, ql}, OK);
      rd(A_QH, {24'h0, qh}, OK);
      rd(A_IL, {24'h0, il}, OK);
    end
    wr(A_MK, 32'h1, OK);
    rd(A_MK, 32'h1, OK);
    for (int k = 0; k < 40; k++) begin
      ql = 8'($urandom);
      qh = 8'($urandom);
      il = 8'($urandom);
      set_borders(ql, qh, il);
      iv = near(il[5:0], {ql[7:6], qh[7:6], il[7:6]});
      qv = near(ql[5:0], qh[5:0]);
      det = exp_det(ql, qh, il, iv, qv);
      measure(iv, qv);
      cmp_irq(irq, det);
      rd(A_ST, {30'h0, 1'b1, det}, OK);
      rd(A_RI, {26'h0, iv}, OK);
      rd(A_RQ, {26'h0, qv}, OK);
      wr(A_ST, 32'h3, OK);
    end
    // suppress: upper I border zero so any nonzero I is outside
    set_borders(8'h00, 8'h3F, 8'h00);
    measure(6'h05, 6'h05);
    rd(A_ST, 32'h3, OK);
    wr(A_RI, 32'hFF, OK);
    rd(A_RI, 32'h05, OK);
    wr(A_RQ, 32'h40, OK);
    repeat (2) @(posedge aclk);
    cmp_irq(irq, 1'b0);
    rd(A_RQ, 32'h45, OK);
    rd(A_ST, 32'h2, OK);
    measure(6'h06, 6'h06);
    cmp_irq(irq, 1'b0);
    rd(A_ST, 32'h2, OK);
    @(posedge aclk);
    detect_start <= 1'b1;
    @(posedge aclk);
    detect_start <= 1'b0;
    rd(A_RQ, 32'h06, OK);
    measure(6'h07, 6'h07);
    cmp_irq(irq, 1'b1);
    rd(A_ST, 32'h3, OK);
    // mask follows the status layout
    wr(A_MK, 32'h0, OK);
    repeat (2) @(posedge aclk);
    cmp_irq(irq, 1'b0);
    wr(A_MK, 32'h2, OK);
    wr(A_ST, 32'h1, OK);
    repeat (2) @(posedge aclk);
    cmp_irq(irq, 1'b1);
    rd(A_ST, 32'h2, OK);
    wr(A_ST, 32'h2, OK);
    repeat (2) @(posedge aclk);
    cmp_irq(irq, 1'b0);
    final_report();
  end
endmodule
